//--- shared/pim_pkg.sv
// Package of constants for the pin interrupt and pattern match block
package pim_pkg;
    localparam int unsigned NUM_CH      = 8;
    localparam int unsigned NUM_PINS    = 32;
    localparam int unsigned SEL_W       = 5;
    localparam int unsigned NUM_TERMS   = 8;
    localparam int unsigned NUM_DMA_CH  = 2;
    localparam int unsigned SLICE_W     = 3;

    // Per-slice condition codes in pattern match mode
    localparam logic [2:0] COND_ALWAYS  = 3'h0;
    localparam logic [2:0] COND_STK_RISE = 3'h1;
    localparam logic [2:0] COND_STK_FALL = 3'h2;
    localparam logic [2:0] COND_STK_ANY = 3'h3;
    localparam logic [2:0] COND_HIGH    = 3'h4;
    localparam logic [2:0] COND_LOW     = 3'h5;
    localparam logic [2:0] COND_NEVER   = 3'h6;
    localparam logic [2:0] COND_EV_ANY  = 3'h7;

    localparam logic [7:0] ZERO8        = 8'h00;
    localparam logic [1:0] SYNC_ZERO    = 2'h0;
endpackage : pim_pkg

//--- hdl/pim_engine.sv
// Pin interrupt and pattern match engine, single clock, plain control ports
`timescale 1ns/1ps
module pim_engine
    import pim_pkg::*;
(
    input  wire logic                      i_core_clk,
    input  wire logic                      i_rst_n,
    input  wire logic [NUM_PINS-1:0]       i_pins,
    input  wire logic [NUM_CH*SEL_W-1:0]   i_pin_sel,
    input  wire logic [NUM_CH-1:0]         i_level_mode,
    input  wire logic [NUM_CH-1:0]         i_rise_en,
    input  wire logic [NUM_CH-1:0]         i_fall_en,
    input  wire logic [NUM_CH-1:0]         i_level_en,
    input  wire logic [NUM_CH-1:0]         i_level_high,
    input  wire logic [NUM_CH-1:0]         i_rise_clr,
    input  wire logic [NUM_CH-1:0]         i_fall_clr,
    input  wire logic                      i_pattern_mode,
    input  wire logic [NUM_CH*3-1:0]       i_slice_cond,
    input  wire logic [NUM_CH*3-1:0]       i_slice_src,
    input  wire logic [NUM_CH-1:0]         i_term_end,
    input  wire logic                      i_cpu_receive_event_en,
    input  wire logic [NUM_CH-1:0]         i_edge_det_clr,
    output logic      [NUM_CH-1:0]         o_irq,
    output logic      [NUM_CH-1:0]         o_wake,
    output logic      [NUM_CH-1:0]         o_rise_flag,
    output logic      [NUM_CH-1:0]         o_fall_flag,
    output logic      [NUM_TERMS-1:0]      o_term_match,
    output logic                           o_cpu_receive_event,
    output logic      [NUM_DMA_CH-1:0]     o_dma_trig
);

    // ------------------------------------------------------------------
    // Pin selection
    // ------------------------------------------------------------------
    logic [NUM_CH-1:0] sel_pin;

    always_comb begin
        for (int c = 0; c < NUM_CH; c++) begin
            sel_pin[c] = i_pins[i_pin_sel[c*SEL_W +: SEL_W]];
        end
    end

    // ------------------------------------------------------------------
    // Synchronisation and filtering, one filter per channel
    // ------------------------------------------------------------------
    logic [NUM_CH-1:0] level;
    logic [NUM_CH-1:0] level_d;
    logic [NUM_CH-1:0] rise_ev;
    logic [NUM_CH-1:0] fall_ev;

    for (genvar c = 0; c < NUM_CH; c++) begin : g_filt
        pim_pin_filter u_pim_pin_filter (
            .i_core_clk (i_core_clk),
            .i_pin      (sel_pin[c]),
            .o_level    (level[c]),
            .o_level_d  (level_d[c])
        );
    end

    assign rise_ev = level & ~level_d;
    assign fall_ev = ~level & level_d;

    // ------------------------------------------------------------------
    // Pin interrupt mode: sticky edge flags
    // ------------------------------------------------------------------
    logic [NUM_CH-1:0] next_rise_flag;
    logic [NUM_CH-1:0] next_fall_flag;

    pim_sticky_flag #(
        .WIDTH (NUM_CH)
    ) u_rise_flag (
        .i_core_clk (i_core_clk),
        .i_rst_n    (i_rst_n),
        .i_set      (rise_ev),
        .i_clr      (i_rise_clr),
        .o_flag     (o_rise_flag),
        .o_next     (next_rise_flag)
    );

    pim_sticky_flag #(
        .WIDTH (NUM_CH)
    ) u_fall_flag (
        .i_core_clk (i_core_clk),
        .i_rst_n    (i_rst_n),
        .i_set      (fall_ev),
        .i_clr      (i_fall_clr),
        .o_flag     (o_fall_flag),
        .o_next     (next_fall_flag)
    );

    // ------------------------------------------------------------------
    // Pin interrupt mode: request per channel
    // ------------------------------------------------------------------
    logic [NUM_CH-1:0] pin_req;

    always_comb begin
        for (int c = 0; c < NUM_CH; c++) begin
            if (i_level_mode[c]) begin
                pin_req[c] = i_level_en[c] & (level[c] == i_level_high[c]);
            end else begin
                pin_req[c] = (i_rise_en[c] & next_rise_flag[c])
                           | (i_fall_en[c] & next_fall_flag[c]);
            end
        end
    end

    // ------------------------------------------------------------------
    // Pattern match: sticky edge detectors per input
    // ------------------------------------------------------------------
    logic [NUM_CH-1:0] stk_rise;
    logic [NUM_CH-1:0] stk_fall;

    pim_sticky_flag #(
        .WIDTH (NUM_CH)
    ) u_stk_rise (
        .i_core_clk (i_core_clk),
        .i_rst_n    (i_rst_n),
        .i_set      (rise_ev),
        .i_clr      (i_edge_det_clr),
        .o_flag     (stk_rise),
        .o_next     ()
    );

    pim_sticky_flag #(
        .WIDTH (NUM_CH)
    ) u_stk_fall (
        .i_core_clk (i_core_clk),
        .i_rst_n    (i_rst_n),
        .i_set      (fall_ev),
        .i_clr      (i_edge_det_clr),
        .o_flag     (stk_fall),
        .o_next     ()
    );

    // ------------------------------------------------------------------
    // Pattern match: slice evaluation and minterm chaining
    // ------------------------------------------------------------------
    logic [NUM_CH-1:0]    slice_true;
    logic [NUM_TERMS-1:0] term_hit;
    logic                 any_match;

    always_comb begin
        logic [SLICE_W-1:0] src;
        src = '0;
        for (int s = 0; s < NUM_CH; s++) begin
            src = i_slice_src[s*SLICE_W +: SLICE_W];
            unique case (i_slice_cond[s*SLICE_W +: SLICE_W])
                COND_ALWAYS:   slice_true[s] = 1'b1;
                COND_STK_RISE: slice_true[s] = stk_rise[src];
                COND_STK_FALL: slice_true[s] = stk_fall[src];
                COND_STK_ANY:  slice_true[s] = stk_rise[src] | stk_fall[src];
                COND_HIGH:     slice_true[s] = level[src];
                COND_LOW:      slice_true[s] = ~level[src];
                COND_NEVER:    slice_true[s] = 1'b0;
                COND_EV_ANY:   slice_true[s] = rise_ev[src] | fall_ev[src];
            endcase
        end
    end

    // Products restart after each closing slice
    always_comb begin
        logic acc;
        acc = 1'b1;
        any_match = 1'b0;
        for (int s = 0; s < NUM_CH; s++) begin
            acc = acc & slice_true[s];
            // The last slice always closes a term
            term_hit[s] = acc & (i_term_end[s] | (s == NUM_CH - 1));
            if (term_hit[s]) begin
                any_match = 1'b1;
            end
            if (i_term_end[s]) begin
                acc = 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Interrupt, wake and term outputs
    // ------------------------------------------------------------------
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            o_irq <= ZERO8;
        end else if (i_pattern_mode) begin
            o_irq <= term_hit;
        end else begin
            o_irq <= pin_req;
        end
    end

    // Pattern results never wake the chip
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            o_wake <= ZERO8;
        end else if (i_pattern_mode) begin
            o_wake <= ZERO8;
        end else begin
            o_wake <= pin_req;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            o_term_match <= ZERO8;
        end else if (i_pattern_mode) begin
            o_term_match <= term_hit;
        end else begin
            o_term_match <= ZERO8;
        end
    end

    // ------------------------------------------------------------------
    // Receive event toward the processor
    // ------------------------------------------------------------------
    logic any_match_d;

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            any_match_d <= 1'b0;
        end else begin
            any_match_d <= any_match & i_pattern_mode;
        end
    end

    // One pulse per rising match condition
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            o_cpu_receive_event <= 1'b0;
        end else begin
            o_cpu_receive_event <= i_cpu_receive_event_en & i_pattern_mode & any_match & ~any_match_d;
        end
    end

    // ------------------------------------------------------------------
    // DMA trigger sources
    // ------------------------------------------------------------------
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            o_dma_trig <= SYNC_ZERO;
        end else if (i_pattern_mode) begin
            o_dma_trig <= term_hit[NUM_DMA_CH-1:0];
        end else begin
            o_dma_trig <= pin_req[NUM_DMA_CH-1:0];
        end
    end

endmodule : pim_engine

// ----------------------------------------------------------------------
// Three-stage pin synchroniser with agreement filter
// ----------------------------------------------------------------------
module pim_pin_filter (
    input  wire logic i_core_clk,
    input  wire logic i_pin,
    output logic      o_level,
    output logic      o_level_d
);
    logic sync1;
    logic sync2;
    logic sync3;

    // Runs through reset so that release brings no false edge
    always_ff @(posedge i_core_clk) begin
        sync1 <= i_pin;
        sync2 <= sync1;
        sync3 <= sync2;
    end

    // Level moves only once the last two stages agree
    always_ff @(posedge i_core_clk) begin
        if (sync2 == sync3) begin
            o_level <= sync3;
        end
    end

    always_ff @(posedge i_core_clk) begin
        o_level_d <= o_level;
    end
endmodule : pim_pin_filter

// ----------------------------------------------------------------------
// Sticky flag vector, set wins over clear
// ----------------------------------------------------------------------
module pim_sticky_flag #(
    parameter int unsigned WIDTH = 8
) (
    input  wire logic             i_core_clk,
    input  wire logic             i_rst_n,
    input  wire logic [WIDTH-1:0] i_set,
    input  wire logic [WIDTH-1:0] i_clr,
    output logic      [WIDTH-1:0] o_flag,
    output logic      [WIDTH-1:0] o_next
);
    // A set in the clearing cycle is kept
    always_comb begin
        o_next = (o_flag & ~i_clr) | i_set;
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            o_flag <= '0;
        end else begin
            o_flag <= o_next;
        end
    end
endmodule : pim_sticky_flag

//--- tb/pim_engine_asserts.sv
// Checker of the engine's output relations
`timescale 1ns/1ps
module pim_engine_asserts
    import pim_pkg::*;
(
    input  wire logic                  i_core_clk,
    input  wire logic                  i_rst_n,
    input  wire logic                  i_pattern_mode,
    input  wire logic                  i_cpu_receive_event_en,
    input  wire logic [NUM_CH-1:0]     i_rise_clr,
    input  wire logic [NUM_CH-1:0]     i_fall_clr,
    input  wire logic [NUM_CH-1:0]     o_irq,
    input  wire logic [NUM_CH-1:0]     o_wake,
    input  wire logic [NUM_CH-1:0]     o_rise_flag,
    input  wire logic [NUM_CH-1:0]     o_fall_flag,
    input  wire logic [NUM_TERMS-1:0]  o_term_match,
    input  wire logic                  o_cpu_receive_event,
    input  wire logic [NUM_DMA_CH-1:0] o_dma_trig
);
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);
    a_dma_mirror: assert property (o_dma_trig == o_irq[1:0]) else $error("dma trigger differs");
    a_wake_subset: assert property ((o_wake & ~o_irq) == ZERO8) else $error("wake without request");
    a_wake_pattern: assert property (i_pattern_mode && $past(i_pattern_mode) && $past(i_pattern_mode, 2)
        |-> o_wake == ZERO8) else $error("wake in pattern mode");
    a_term_pin: assert property (!i_pattern_mode && $past(!i_pattern_mode) && $past(!i_pattern_mode, 2)
        |-> o_term_match == ZERO8) else $error("term hit in pin mode");
    a_cpu_receive_event_one: assert property (o_cpu_receive_event |=> !o_cpu_receive_event) else $error("event too long");
    a_cpu_receive_event_off: assert property (!i_cpu_receive_event_en && $past(!i_cpu_receive_event_en) && $past(!i_cpu_receive_event_en, 2)
        |-> !o_cpu_receive_event) else $error("event while disabled");
    a_rise_stick: assert property ((($past(o_rise_flag) & ~$past(i_rise_clr)) & ~o_rise_flag) == ZERO8)
        else $error("rise flag dropped");
    a_fall_stick: assert property ((($past(o_fall_flag) & ~$past(i_fall_clr)) & ~o_fall_flag) == ZERO8)
        else $error("fall flag dropped");
endmodule : pim_engine_asserts
bind pim_engine pim_engine_asserts u_pim_engine_asserts (.i_core_clk, .i_rst_n, .i_pattern_mode, .i_cpu_receive_event_en,
    .i_rise_clr, .i_fall_clr, .o_irq, .o_wake, .o_rise_flag, .o_fall_flag, .o_term_match,
    .o_cpu_receive_event, .o_dma_trig);

//--- tb/pim_core_sink.sv
// Far side model: processor event input counting pulses
`timescale 1ns/1ps
module pim_core_sink (
    input  wire logic i_core_clk,
    input  wire logic i_ev,
    output int        o_ev_count
);
    initial o_ev_count = 0;
    always @(posedge i_core_clk) begin
        if (i_ev === 1'b1) o_ev_count <= o_ev_count + 1;
    end
endmodule : pim_core_sink

//--- tb/tb_pim_engine.sv
// Self-checking bench for the pin interrupt and pattern match engine
`timescale 1ns/1ps
module tb_pim_engine;
    import pim_pkg::*;
    logic        clk = 1'b0, rst_n = 1'b0, pm = 1'b0, rxe = 1'b0, ev;
    logic [31:0] pins = '0;
    logic [39:0] sel;
    logic [23:0] cond = '0, src;
    logic [7:0]  lm = '0, re = '0, fe = '0, le = '0, lh = '0, rc = '0, fc = '0, te = 8'hFF, ec = '0;
    logic [7:0]  irq, wake, rf, ff, tm, e;
    logic [1:0]  dma;
    logic [2:0]  conds [4] = '{COND_NEVER, COND_ALWAYS, COND_HIGH, COND_LOW};
    int          n_mismatch = 0, num_checks = 0, evc, b;
    always #20 clk = ~clk;
    pim_engine u_pim_engine (.i_core_clk(clk), .i_rst_n(rst_n), .i_pins(pins), .i_pin_sel(sel),
        .i_level_mode(lm), .i_rise_en(re), .i_fall_en(fe), .i_level_en(le), .i_level_high(lh),
        .i_rise_clr(rc), .i_fall_clr(fc), .i_pattern_mode(pm), .i_slice_cond(cond), .i_slice_src(src),
        .i_term_end(te), .i_cpu_receive_event_en(rxe), .i_edge_det_clr(ec), .o_irq(irq), .o_wake(wake),
        .o_rise_flag(rf), .o_fall_flag(ff), .o_term_match(tm), .o_cpu_receive_event(ev), .o_dma_trig(dma));
    pim_core_sink u_pim_core_sink (.i_core_clk(clk), .i_ev(ev), .o_ev_count(evc));
    function automatic logic [7:0] lvl();
        for (int c = 0; c < 8; c++) lvl[c] = pins[sel[c*5+:5]];
    endfunction : lvl
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : finish_test
    initial begin
        repeat (3000) @(posedge clk);
        n_mismatch++;
        finish_test();
    end
    initial begin
        b = $urandom(37);
        b = $urandom % 4;
        for (int c = 0; c < 8; c++) begin
            sel[c*5+:5] = 5'(c * 4 + b);
            src[c*3+:3] = 3'(c);
        end
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        re <= 8'h35;
        fe <= 8'h5C;
        cyc(4);
        @(posedge clk) pins <= '1;
        cyc(8);
        chk(rf, 8'hFF);
        chk(irq, re);
        @(posedge clk) pins <= '0;
        cyc(8);
        chk(irq, re | fe);
        @(posedge clk) {rc, fc} <= 16'hFFFF;
        @(posedge clk) {rc, fc} <= 16'h0000;
        @(posedge clk) pins <= '1;
        @(posedge clk) pins <= '0;
        cyc(8);
        chk(rf | ff, 8'h00);
        @(posedge clk) lm <= 8'hFF;
        le <= 8'hFF;
        for (int i = 0; i < 3; i++) begin
            @(posedge clk) pins <= $urandom;
            lh <= 8'($urandom);
            cyc(8);
            e = ~(lvl() ^ lh);
            chk(irq, e);
            chk(wake, e);
            chk({6'h00, dma}, e & 8'h03);
        end
        @(posedge clk) {pm, rxe, lm, ec} <= {2'h3, 8'h00, 8'hFF};
        @(posedge clk) ec <= 8'h00;
        foreach (conds[k]) begin
            @(posedge clk) cond <= {8{conds[k]}};
            cyc(8);
            e = (k == 0) ? 8'h00 : (k == 1) ? 8'hFF : (k == 2) ? lvl() : ~lvl();
            chk(tm, e);
            chk(irq, e);
            chk(wake, 8'h00);
            if (k == 0) b = evc;
            if (k == 1) chk(8'(evc - b), 8'h01);
        end
        @(posedge clk) pins <= '1;
        cyc(8);
        @(posedge clk) ec <= 8'hFF;
        @(posedge clk) ec <= 8'h00;
        cond <= {8{COND_STK_ANY}};
        cyc(8);
        chk(tm, 8'h00);
        @(posedge clk) pins <= '0;
        cond <= {8{COND_EV_ANY}};
        b = evc;
        cyc(8);
        chk(8'(evc - b), 8'h01);
        chk(tm, 8'h00);
        @(posedge clk) cond <= {8{COND_STK_FALL}};
        cyc(8);
        chk(tm, 8'hFF);
        @(posedge clk) ec <= 8'hFF;
        @(posedge clk) ec <= 8'h00;
        pins <= '1;
        cond <= {8{COND_STK_RISE}};
        cyc(8);
        chk(tm, 8'hFF);
        @(posedge clk) te <= 8'h88;
        cond <= {COND_NEVER, {7{COND_STK_RISE}}};
        cyc(8);
        chk(tm, 8'h08);
        chk(irq, 8'h08);
        chk(wake, 8'h00);
        finish_test();
    end
endmodule : tb_pim_engine
